/* File: core/seq_run_pkg.sv */
// Package: constants for the sequence run control block
package seq_run_pkg;
   // ==========================================
   // Register map
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_TARGET = 4'h1;
   localparam logic [3:0] OFF_STATUS = 4'h2;
   localparam logic [3:0] OFF_IRQ_STAT = 4'h3;
   localparam logic [3:0] OFF_IRQ_MASK = 4'h4;
   localparam logic [3:0] OFF_RMT_SEL = 4'h5;
   localparam logic [3:0] OFF_LAST = 4'h6;
   // ==========================================
   // Control register bits (bits 0-2 write-one pulses, bits 3-4 stored start assignment)
   localparam int CTRL_RUN = 0;
   localparam int CTRL_ABORT = 1;
   localparam int CTRL_SEQUENCE_EDITOR_COMMAND = 2;
   localparam int CTRL_START_LOCAL = 3;
   localparam int CTRL_START_REMOTE = 4;
   // ==========================================
   // Interrupt status bits
   localparam int IRQ_STARTED = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_ABORTED = 2;
   localparam int IRQ_REJECTED = 3;
   localparam int IRQ_W = 4;
   // ==========================================
   // Reset values and widths
   localparam int TARGET_W = 8;
   localparam int RMT_SEL_W = 4;
   localparam logic [7:0] ESC_CHAR = 8'h1b;
   localparam logic [RMT_SEL_W-1:0] RMT_SEL_RESET = 4'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
   localparam logic [1:0] ASSIGN_RESET = 2'h0;
   typedef enum {ST_IDLE, ST_RUNNING} run_state_t;
endpackage

/* File: core/sync_two_ff.sv */
// Two flip-flop synchroniser for a bundle of pin inputs
module sync_two_ff #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         syncOut <= '0;
      end else begin
         meta_q <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule // sync_two_ff

/* File: core/sequence_run_control.sv */
// Run control of the stored-sequence executor
// Notes on behaviour
// - Run command starts the named sequence
// - Assigned start input also starts a sequence
// - No start while an alarm is active
// - Prompt returns; sequence runs in background
// - Alarm or abort input aborts the run
// - Abort command or escape aborts the run
// - Run command from a sequence is refused
// - Editor blocked while a sequence runs
// - Running status query reads one meanwhile
// - Running status routable to remote output
module sequence_run_control
   import seq_run_pkg::*;
#(
   parameter int NUM_RMT_OUT = 1 << RMT_SEL_W
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic [7:0] rxChar,
   input wire logic rxValid,
   input wire logic cmdFromSeq,
   input wire logic startPin,
   input wire logic abortPin,
   input wire logic startRemote,
   input wire logic alarmActive,
   input wire logic seqDone,
   output logic seqRunning,
   output logic [TARGET_W-1:0] seqTarget,
   output logic seqStart,
   output logic editorGrant,
   output logic [NUM_RMT_OUT-1:0] remoteOut,
   output logic irq
);
   // ==========================================
   // Pin inputs
   logic [1:0] pinSync;
   logic startPinPrev_q;
   logic startPinRise;

   sync_two_ff #(.WIDTH(2)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .asyncIn({abortPin, startPin}),
      .syncOut(pinSync)
   );

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         startPinPrev_q <= 1'b0;
      end else begin
         startPinPrev_q <= pinSync[0];
      end
   end
   assign startPinRise = pinSync[0] && !startPinPrev_q;

   // ==========================================
   // Software-visible state
   logic [TARGET_W-1:0] target_q;
   logic [1:0] assign_q;
   logic [RMT_SEL_W-1:0] rmtSel_q;
   logic [IRQ_W-1:0] irqStat_q;
   logic [IRQ_W-1:0] irqMask_q;
   logic wrCtrl;
   logic runCmd;
   logic abortCmd;
   logic editReq;
   logic escSeen;

   assign wrCtrl = regWr && (regAddr == OFF_CTRL);
   assign runCmd = wrCtrl && regWdata[CTRL_RUN];
   assign abortCmd = wrCtrl && regWdata[CTRL_ABORT];
   assign editReq = wrCtrl && regWdata[CTRL_SEQUENCE_EDITOR_COMMAND];
   assign escSeen = rxValid && (rxChar == ESC_CHAR);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         target_q <= '0;
         assign_q <= ASSIGN_RESET;
         rmtSel_q <= RMT_SEL_RESET;
         irqMask_q <= IRQ_MASK_RESET;
      end else if (regWr) begin
         case (regAddr)
            OFF_TARGET: target_q <= regWdata[TARGET_W-1:0];
            OFF_CTRL: assign_q <= regWdata[CTRL_START_REMOTE:CTRL_START_LOCAL];
            OFF_IRQ_MASK: irqMask_q <= regWdata[IRQ_W-1:0];
            OFF_RMT_SEL: rmtSel_q <= regWdata[RMT_SEL_W-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================
   // Run state machine
   run_state_t state_q;
   logic startReq;
   logic startOk;
   logic abortNow;
   logic rejectEv;

   assign startReq = (runCmd && !cmdFromSeq)
                     || (startPinRise && assign_q[0])
                     || (startRemote && assign_q[1]);
   // Alarm refuses, running ignores; refused start is flagged
   assign startOk = startReq && !alarmActive && (state_q == ST_IDLE);
   assign rejectEv = startReq && alarmActive && (state_q == ST_IDLE);
   assign abortNow = alarmActive || pinSync[1] || abortCmd || escSeen;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: if (startOk) state_q <= ST_RUNNING;
            ST_RUNNING: if (abortNow || seqDone) state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // Outputs, all registered
   logic runNext;
   assign runNext = (state_q == ST_IDLE) ? startOk : !(abortNow || seqDone);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         seqRunning <= 1'b0;
         seqStart <= 1'b0;
         seqTarget <= '0;
         editorGrant <= 1'b0;
         remoteOut <= '0;
      end else begin
         seqRunning <= runNext;
         seqStart <= startOk;
         if (startOk) begin
            seqTarget <= target_q;
         end
         editorGrant <= editReq && !runNext && (state_q == ST_IDLE);
         remoteOut <= '0;
         if (rmtSel_q != '0) begin
            remoteOut[rmtSel_q] <= runNext;
         end
      end
   end

   // ==========================================
   // Interrupt status, set wins over clear
   logic [IRQ_W-1:0] irqSet;
   logic [IRQ_W-1:0] irqClr;
   logic endRun;
   assign endRun = state_q == ST_RUNNING;
   assign irqSet = {rejectEv, endRun && abortNow, endRun && seqDone && !abortNow, startOk};
   assign irqClr = (regWr && regAddr == OFF_IRQ_STAT) ? regWdata[IRQ_W-1:0] : '0;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStat_q <= '0;
         irq <= 1'b0;
      end else begin
         irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
         irq <= |(((irqStat_q & ~irqClr) | irqSet) & irqMask_q);
      end
   end

   // ==========================================
   // Read port
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= '0;
      end else if (regRd) begin
         case (regAddr)
            OFF_CTRL: regRdata <= {27'h0, assign_q, 3'h0};
            OFF_TARGET: regRdata <= {24'h0, target_q};
            OFF_STATUS: regRdata <= {31'h0, seqRunning};
            OFF_IRQ_STAT: regRdata <= {28'h0, irqStat_q};
            OFF_IRQ_MASK: regRdata <= {28'h0, irqMask_q};
            OFF_RMT_SEL: regRdata <= {28'h0, rmtSel_q};
            default: regRdata <= '0;
         endcase
      end else begin
         regRdata <= '0;
      end
   end

   // ==========================================
   // Checks
   property p_alarm_blocks;
      @(posedge sys_clk) disable iff (!rst_n)
      alarmActive |=> !seqStart;
   endproperty
   a_alarm_blocks: assert property (p_alarm_blocks) else $error("start during alarm");

   property p_start_runs;
      @(posedge sys_clk) disable iff (!rst_n)
      seqStart |-> seqRunning && !$past(seqRunning);
   endproperty
   a_start_runs: assert property (p_start_runs) else $error("start without run");

   property p_abort_stops;
      @(posedge sys_clk) disable iff (!rst_n)
      (seqRunning && (pinSync[1] || abortCmd || escSeen)) |=> !seqRunning;
   endproperty
   a_abort_stops: assert property (p_abort_stops) else $error("abort ignored");

   property p_alarm_stops;
      @(posedge sys_clk) disable iff (!rst_n)
      alarmActive |=> !seqRunning;
   endproperty
   a_alarm_stops: assert property (p_alarm_stops) else $error("alarm ignored");

   property p_nested_run;
      @(posedge sys_clk) disable iff (!rst_n)
      (runCmd && cmdFromSeq && !startPinRise && !startRemote) |=> !seqStart;
   endproperty
   a_nested_run: assert property (p_nested_run) else $error("run from sequence");

   property p_editor_locked;
      @(posedge sys_clk) disable iff (!rst_n)
      editorGrant |-> !seqRunning && !$past(seqRunning);
   endproperty
   a_editor_locked: assert property (p_editor_locked) else $error("editor while running");

   property p_no_restart;
      @(posedge sys_clk) disable iff (!rst_n)
      seqRunning && !seqDone |=> !seqStart;
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("restart while running");

   property p_done_clears;
      @(posedge sys_clk) disable iff (!rst_n)
      (seqRunning && seqDone) |=> !seqRunning && (irqStat_q[IRQ_DONE] || irqStat_q[IRQ_ABORTED]);
   endproperty
   a_done_clears: assert property (p_done_clears) else $error("done not seen");

   property p_status_read;
      @(posedge sys_clk) disable iff (!rst_n)
      (regRd && regAddr == OFF_STATUS) |=> regRdata[0] == $past(seqRunning);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_start_target;
      @(posedge sys_clk) disable iff (!rst_n)
      seqStart |-> seqTarget == $past(target_q);
   endproperty
   a_start_target: assert property (p_start_target) else $error("wrong target");

   property p_run_starts;
      @(posedge sys_clk) disable iff (!rst_n)
      (runCmd && !cmdFromSeq && !alarmActive && !seqRunning) |=> seqStart && seqRunning;
   endproperty
   a_run_starts: assert property (p_run_starts) else $error("run command lost");

   property p_pin_start;
      @(posedge sys_clk) disable iff (!rst_n)
      (startPinRise && assign_q[0] && !alarmActive && !seqRunning) |=> seqStart;
   endproperty
   a_pin_start: assert property (p_pin_start) else $error("start pin lost");

   property p_remote_start;
      @(posedge sys_clk) disable iff (!rst_n)
      (startRemote && assign_q[1] && !alarmActive && !seqRunning) |=> seqStart;
   endproperty
   a_remote_start: assert property (p_remote_start) else $error("remote start lost");

   property p_no_source;
      @(posedge sys_clk) disable iff (!rst_n)
      !(runCmd || (startPinRise && assign_q[0]) || (startRemote && assign_q[1])) |=> !seqStart;
   endproperty
   a_no_source: assert property (p_no_source) else $error("start from nowhere");

   property p_reject_flag;
      @(posedge sys_clk) disable iff (!rst_n)
      (startReq && alarmActive && !seqRunning) |=> irqStat_q[IRQ_REJECTED] && !seqStart;
   endproperty
   a_reject_flag: assert property (p_reject_flag) else $error("refusal not flagged");

   property p_run_holds;
      @(posedge sys_clk) disable iff (!rst_n)
      (seqRunning && !seqDone && !alarmActive && !pinSync[1] && !abortCmd && !escSeen)
         |=> seqRunning;
   endproperty
   a_run_holds: assert property (p_run_holds) else $error("run dropped");

   property p_abort_pin;
      @(posedge sys_clk) disable iff (!rst_n)
      (seqRunning && pinSync[1]) |=> !seqRunning && irqStat_q[IRQ_ABORTED];
   endproperty
   a_abort_pin: assert property (p_abort_pin) else $error("abort pin ignored");

   property p_alarm_flag;
      @(posedge sys_clk) disable iff (!rst_n)
      (seqRunning && alarmActive) |=> irqStat_q[IRQ_ABORTED];
   endproperty
   a_alarm_flag: assert property (p_alarm_flag) else $error("alarm abort not flagged");

   property p_other_char;
      @(posedge sys_clk) disable iff (!rst_n)
      (seqRunning && rxValid && rxChar != ESC_CHAR && !seqDone && !alarmActive
         && !pinSync[1] && !abortCmd) |=> seqRunning;
   endproperty
   a_other_char: assert property (p_other_char) else $error("plain char aborted");

   property p_started_flag;
      @(posedge sys_clk) disable iff (!rst_n)
      seqStart |-> irqStat_q[IRQ_STARTED];
   endproperty
   a_started_flag: assert property (p_started_flag) else $error("start not flagged");

   property p_editor_grant;
      @(posedge sys_clk) disable iff (!rst_n)
      (editReq && !seqRunning && !startReq) |=> editorGrant;
   endproperty
   a_editor_grant: assert property (p_editor_grant) else $error("editor refused idle");

   property p_editor_busy;
      @(posedge sys_clk) disable iff (!rst_n)
      (editReq && seqRunning) |=> !editorGrant;
   endproperty
   a_editor_busy: assert property (p_editor_busy) else $error("editor granted busy");

   property p_irq_level;
      @(posedge sys_clk) disable iff (!rst_n)
      !$past(regWr) |-> irq == |(irqStat_q & irqMask_q);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

   property p_rout_follow;
      @(posedge sys_clk) disable iff (!rst_n)
      (rmtSel_q != '0 && rmtSel_q == $past(rmtSel_q)) |-> remoteOut[rmtSel_q] == seqRunning;
   endproperty
   a_rout_follow: assert property (p_rout_follow) else $error("remote output wrong");

   property p_rout_unassigned;
      @(posedge sys_clk) disable iff (!rst_n)
      ($past(rmtSel_q) == '0) |-> remoteOut == '0;
   endproperty
   a_rout_unassigned: assert property (p_rout_unassigned) else $error("stray output");

   property p_rdata_quiet;
      @(posedge sys_clk) disable iff (!rst_n)
      !regRd |=> regRdata == '0;
   endproperty
   a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data not cleared");

   c_pin_start: cover property (@(posedge sys_clk) disable iff (!rst_n) startPinRise ##1 seqStart);

   c_run_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
      seqStart ##[1:50] (seqRunning && seqDone));
   c_rejected: cover property (@(posedge sys_clk) disable iff (!rst_n) rejectEv);
   c_escape: cover property (@(posedge sys_clk) disable iff (!rst_n) seqRunning && escSeen);
endmodule // sequence_run_control

/* File: tb/seq_exec_model.sv */
// Executor stand-in: ends a started sequence after a set run length
module seq_exec_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic seqStart,
   input wire logic seqRunning,
   input wire logic [7:0] runLen,
   output logic seqDone
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] left_q;
   // ==========================================
   // Run length countdown
   // Zero run length: the sequence only ends by an abort
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         left_q <= 8'h00;
         seqDone <= 1'b0;
      end else begin
         seqDone <= (left_q == 8'h01) && seqRunning;
         if (seqStart) begin
            left_q <= runLen;
         end else if (!seqRunning || left_q == 8'h01) begin
            left_q <= 8'h00;
         end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
         end
      end
   end
endmodule // seq_exec_model

/* File: tb/tb_top.sv */
// Self-checking bench for the sequence run control block
module tb_top;
   import seq_run_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Signals and bookkeeping
   logic sys_clk = 0, rst_n = 0, regWr = 0, regRd = 0, rxValid = 0, cmdFromSeq = 0;
   logic startPin = 0, abortPin = 0, startRemote = 0, alarmActive = 0, seqDone;
   logic seqRunning, seqStart, editorGrant, irq, rdSeen = 0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0, regRdata;
   logic [7:0] rxChar = 8'h00, seqTarget, runLen = 8'h14, tgt;
   logic [15:0] remoteOut;
   logic [31:0] rq[$];
   logic [7:0] tq[$];
   int n_fail = 0, n_checks = 0, grants = 0;
   integer seed = 18;
   sequence_run_control i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .rxChar(rxChar), .rxValid(rxValid), .cmdFromSeq(cmdFromSeq), .startPin(startPin),
      .abortPin(abortPin), .startRemote(startRemote), .alarmActive(alarmActive),
      .seqDone(seqDone), .seqRunning(seqRunning), .seqTarget(seqTarget),
      .seqStart(seqStart), .editorGrant(editorGrant), .remoteOut(remoteOut), .irq(irq));
   seq_exec_model i_exec (.sys_clk(sys_clk), .rst_n(rst_n), .seqStart(seqStart),
      .seqRunning(seqRunning), .runLen(runLen), .seqDone(seqDone));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // ==========================================
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Strobe then one idle edge, so a strobe is never set twice in one step
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      cyc(1);
      regWr <= 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      rq.push_back(exp);
      regAddr <= a;
      regRd <= 1'b1;
      cyc(1);
      regRd <= 1'b0;
      cyc(1);
   endtask
   task automatic run();
      tgt = 8'($random(seed));
      wr(OFF_TARGET, {24'h0, tgt});
      tq.push_back(tgt);
      wr(OFF_CTRL, 32'h1);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ==========================================
   // Output watcher: oldest note against each result
   always @(negedge sys_clk) begin
      if (rdSeen) chk(regRdata, rq.pop_front());
      rdSeen = (regRd === 1'b1);
      if (editorGrant === 1'b1) grants++;
      if (seqStart === 1'b1) begin
         if (tq.size() == 0) chk(32'h1, 32'h0);
         else chk({24'h0, seqTarget}, {24'h0, tq.pop_front()});
      end
   end
   initial begin
      cyc(5000);
      n_fail++;
      wrap_up();
   end
   // ==========================================
   // Main sequence
   initial begin
      cyc(4);
      rst_n <= 1'b1;
      cyc(1);
      rd(OFF_IRQ_MASK, 32'h0);
      rd(OFF_RMT_SEL, 32'h0);
      wr(OFF_RMT_SEL, 32'h3);
      wr(OFF_IRQ_MASK, 32'h8);
      run();
      rd(OFF_STATUS, 32'h1);
      chk(seqRunning, 1'b1);
      chk(32'(remoteOut), 32'h8);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_CTRL, 32'h4);
      chk(grants, 0);
      cyc(25);
      rd(OFF_STATUS, 32'h0);
      chk(32'(remoteOut), 32'h0);
      wr(OFF_CTRL, 32'h4);
      cyc(2);
      chk(grants, 1);
      $display("test run and status done");
      wr(OFF_IRQ_STAT, 32'hf);
      alarmActive <= 1'b1;
      wr(OFF_CTRL, 32'h1);
      cyc(2);
      chk(irq, 1'b1);
      rd(OFF_IRQ_STAT, 32'h8);
      alarmActive <= 1'b0;
      wr(OFF_IRQ_STAT, 32'hf);
      cyc(2);
      chk(irq, 1'b0);
      cmdFromSeq <= 1'b1;
      wr(OFF_CTRL, 32'h1);
      cmdFromSeq <= 1'b0;
      rd(OFF_STATUS, 32'h0);
      $display("test refusals done");
      runLen <= 8'h00;
      for (int k = 0; k < 4; k++) begin
         run();
         cyc(3);
         if (k == 0) wr(OFF_CTRL, 32'h2);
         if (k == 1) begin
            rxChar <= 8'h41;
            rxValid <= 1'b1;
            cyc(1);
            rxValid <= 1'b0;
            rd(OFF_STATUS, 32'h1);
            rxChar <= ESC_CHAR;
            rxValid <= 1'b1;
            cyc(1);
            rxValid <= 1'b0;
         end
         if (k == 2) abortPin <= 1'b1;
         if (k == 3) alarmActive <= 1'b1;
         cyc(5);
         rd(OFF_STATUS, 32'h0);
         abortPin <= 1'b0;
         alarmActive <= 1'b0;
         cyc(4);
      end
      $display("test aborts done");
      runLen <= 8'h0a;
      startPin <= 1'b1;
      cyc(6);
      startPin <= 1'b0;
      rd(OFF_STATUS, 32'h0);
      wr(OFF_CTRL, 32'h8);
      tq.push_back(tgt);
      startPin <= 1'b1;
      cyc(6);
      rd(OFF_STATUS, 32'h1);
      startPin <= 1'b0;
      cyc(12);
      wr(OFF_CTRL, 32'h10);
      tq.push_back(tgt);
      startRemote <= 1'b1;
      cyc(1);
      startRemote <= 1'b0;
      cyc(3);
      rd(OFF_STATUS, 32'h1);
      cyc(12);
      chk(tq.size(), 0);
      rd(OFF_CTRL, 32'h10);
      rd(OFF_TARGET, {24'h0, tgt});
      rd(OFF_IRQ_STAT, 32'h7);
      $display("test start inputs done");
      wrap_up();
   end
endmodule // tb_top
